/* include/pwm_pkg.sv */
// Notes on behaviour
// - Resolution bits are log2 of 4*(period+1)
// - Oversized pulse width leaves pins unchanged
// - Prescaler divides by one, four, sixteen
// - Sleep freezes timer and state, and pins only when all four are PWM owned
// - Output frequency scales with system clock
// - Reset makes pins inputs, clears registers
// - Mode field picks single, half, forward, reverse
// - Half uses two outputs, full bridges four
// - Single mode output needs its steering enable, except A when no other pin is steered
// - Pin polarity selectable through polarity bits
// - Enhanced modes only on first channel
// - Output waits for next full period
// - Zero channel control releases every pin
// - Unused pins stay with port function
// - Period wrap clears timer, sets output unless duty is zero or oversized, loads duty
// - Half bridge: modulated then complement
// - Forward: A active, D modulated, B C inactive
// - Reverse: C active, B modulated, A D inactive
package pwm_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [1:0] PWM_SELECT = 2'h3;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_FORWARD = 2'h1;
  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_REVERSE = 2'h3;
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [3:0] PRESC_LIMIT_1 = 4'h0;
  localparam logic [3:0] PRESC_LIMIT_4 = 4'h3;
  localparam logic [3:0] PRESC_LIMIT_16 = 4'hf;
  localparam logic [1:0] FINE_LAST = 2'h3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [3:0] DIRECTION_RESET = 4'hf;
  localparam logic [3:0] STEER_FIRST_ONLY = 4'h1;
  localparam logic [3:0] HALF_PINS = 4'h3;
  localparam logic [3:0] ALL_PINS = 4'hf;
  localparam int MODE_POS = 6;
  localparam int DUTY_LOW_POS = 4;
  localparam int SELECT_POS = 2;
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_ARMED = 3'h2,
    ST_RUN = 3'h4
  } run_state_t;
endpackage : pwm_pkg

/* include/pwm_timer_if.sv */
`timescale 1ns/1ps
interface pwm_timer_if;
  logic run_en;
  logic [1:0] prescale_select;
  logic [7:0] period_limit;
  logic match_clear;
  logic [9:0] count;
  logic period_start;
  logic match_flag;
  modport timer (input run_en, prescale_select, period_limit, match_clear,
    output count, period_start, match_flag);
  modport stage (output run_en, prescale_select, period_limit, match_clear,
    input count, period_start, match_flag);
endinterface : pwm_timer_if

/* testbench/enhanced_pwm_output_stage_tb.sv */
`timescale 1ns/1ps
module enhanced_pwm_output_stage_tb;
  logic i_clk, i_resetn, run, slp, mclr, dwe;
  logic [7:0] cc, dh, pl, cnt, faults;
  logic [3:0] st, dir, pd, po, oe, own, own2, res;
  logic [1:0] ps;
  logic flag;
  logic [9:0] sh;
  logic [3:0] psnap;
  logic [7:0] csnap;
  int n_fail, check_count, act, per;
  logic [7:0] pl_tab [5] = '{8'hff, 8'h3f, 8'h1f, 8'h17, 8'h00};
  logic [3:0] res_tab [5] = '{4'ha, 4'h8, 4'h7, 4'h6, 4'h2};
  logic [1:0] ps_tab [3] = '{2'h0, 2'h1, 2'h2};
  int div_tab [3] = '{1, 4, 16};
  enhanced_pwm_output_stage dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_channel_control(cc),
    .i_duty_high_bits(dh), .i_period_limit(pl), .i_steer_enable(st), .i_timer_prescale_select(ps),
    .i_timer_run(run), .i_sleep(slp), .i_match_flag_clear(mclr), .i_pin_direction_we(dwe),
    .i_pin_direction(dir), .i_port_data(pd), .o_pin_out(po), .o_pin_oe(oe), .o_pwm_owned(own),
    .o_timer_match_flag(flag), .o_base_timer_count(cnt), .o_duty_active_shadow(sh), .o_resolution_bits(res));
  // Plain channel shares every input with the enhanced one
  enhanced_pwm_output_stage #(.ENHANCED(1'b0)) plain (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_channel_control(cc), .i_duty_high_bits(dh), .i_period_limit(pl), .i_steer_enable(st),
    .i_timer_prescale_select(ps), .i_timer_run(run), .i_sleep(slp), .i_match_flag_clear(mclr),
    .i_pin_direction_we(dwe), .i_pin_direction(dir), .i_port_data(pd), .o_pin_out(), .o_pin_oe(),
    .o_pwm_owned(own2), .o_timer_match_flag(), .o_base_timer_count(), .o_duty_active_shadow(),
    .o_resolution_bits());
  pwm_bridge_model bridge (.i_clk(i_clk), .i_pin_out(po), .i_pin_oe(oe), .o_fault_count(faults));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task tick;
    @(posedge i_clk);
    #5;
  endtask : tick
  task timeout;
    n_fail++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    complete_run;
  endtask : timeout
  task configure(input logic [1:0] mode, input logic [1:0] pol, input logic [9:0] duty,
      input logic [1:0] presc, input logic [3:0] steer);
    int k;
    dwe = 1'b1;
    dir = 4'hf;
    tick;
    dwe = 1'b0;
    pl = 8'h03;
    tick;
    cc = {mode, duty[1:0], pwm_pkg::PWM_SELECT, pol};
    st = steer;
    tick;
    dh = duty[9:2];
    // Duty must be registered before the flag is cleared, so no wrap loads half of it
    tick;
    mclr = 1'b1;
    tick;
    mclr = 1'b0;
    ps = presc;
    run = 1'b1;
    k = 0;
    while (flag !== 1'b1 && k < 3000) begin
      tick;
      k++;
    end
    if (k >= 3000) timeout;
    dwe = 1'b1;
    dir = 4'h0;
    tick;
    dwe = 1'b0;
    tick;
  endtask : configure
  // Time spent at level lv and full period, from one entry into lv to the next
  task measure(input int b, input logic lv, output int a, output int p);
    int k;
    k = 0;
    a = 0;
    p = 0;
    while (po[b] === lv && k < 3000) begin tick; k++; end
    while (po[b] !== lv && k < 3000) begin tick; k++; end
    while (po[b] === lv && k < 3000) begin a++; p++; tick; k++; end
    while (po[b] !== lv && k < 3000) begin p++; tick; k++; end
    if (k >= 3000) timeout;
  endtask : measure
  initial begin
    n_fail = 0;
    check_count = 0;
    {run, slp, mclr, dwe} = 4'h0;
    {cc, dh, pl} = 24'h000000;
    {st, dir, ps} = 10'h000;
    pd = 4'h4;
    i_resetn = 1'b0;
    repeat (16) tick;
    check(oe, 4'h0);
    check(own, 4'h0);
    check({flag, cnt}, 9'h000);
    i_resetn = 1'b1;
    foreach (pl_tab[i]) begin
      pl = pl_tab[i];
      repeat (4) tick;
      check(res, res_tab[i]);
    end
    pl = 8'h03;
    cc = 8'h0c;
    st = 4'h1;
    repeat (3) tick;
    check(po[0], 1'b0);
    check(own, 4'h1);
    // Duty 6 of 16 counts, scaled by each prescale ratio
    foreach (ps_tab[i]) begin
      configure(pwm_pkg::MODE_SINGLE, 2'h0, 10'h006, ps_tab[i], 4'h1);
      measure(0, 1'b1, act, per);
      check(act, 6 * div_tab[i]);
      check(per, 16 * div_tab[i]);
      check(sh, 10'h006);
    end
    check(po[3:1], pd[3:1]);
    configure(pwm_pkg::MODE_SINGLE, 2'h1, 10'h006, pwm_pkg::PRESCALE_DIV1, 4'h1);
    measure(0, 1'b0, act, per);
    check(act, 6);
    configure(pwm_pkg::MODE_HALF, 2'h0, 10'h006, pwm_pkg::PRESCALE_DIV1, 4'h1);
    check(own, pwm_pkg::HALF_PINS);
    check(own2, 4'h1);
    measure(1, 1'b1, act, per);
    check(act, 10);
    check(po[3:2], pd[3:2]);
    configure(pwm_pkg::MODE_FORWARD, 2'h0, 10'h006, pwm_pkg::PRESCALE_DIV1, 4'h1);
    check(own, pwm_pkg::ALL_PINS);
    measure(3, 1'b1, act, per);
    check(act, 6);
    check(po[2:0], 3'h1);
    configure(pwm_pkg::MODE_REVERSE, 2'h0, 10'h006, pwm_pkg::PRESCALE_DIV1, 4'h1);
    measure(1, 1'b1, act, per);
    check(act, 6);
    check({po[3], po[2], po[0]}, 3'h2);
    csnap = cnt;
    psnap = po;
    slp = 1'b1;
    repeat (20) tick;
    check(cnt, csnap);
    check(po, psnap);
    slp = 1'b0;
    repeat (9) tick;
    check(cnt != csnap, 1'b1);
    configure(pwm_pkg::MODE_SINGLE, 2'h0, 10'h3ff, pwm_pkg::PRESCALE_DIV1, 4'h1);
    psnap = po;
    act = 0;
    repeat (48) begin
      tick;
      if (po[0] !== psnap[0]) act++;
    end
    check(act, 0);
    // Pin is low at each wrap, so an oversized width must keep it low
    check(psnap[0], 1'b0);
    cc = 8'h00;
    repeat (3) tick;
    check(own, 4'h0);
    check(po, pd);
    check(faults, 8'h00);
    complete_run;
  end
endmodule : enhanced_pwm_output_stage_tb

/* testbench/pwm_bridge_model.sv */
`timescale 1ns/1ps
module pwm_bridge_model (
  input wire logic i_clk,
  input wire logic [3:0] i_pin_out,
  input wire logic [3:0] i_pin_oe,
  output logic [7:0] o_fault_count
);
  logic [3:0] gate;
  // Undriven pins fall to the external pull-downs, so switches stay off
  assign gate = i_pin_out & i_pin_oe;
  initial o_fault_count = 8'h00;
  // Legs A/B and C/D short the supply if both switches conduct
  always @(posedge i_clk) begin
    if ((gate[0] && gate[1]) || (gate[2] && gate[3])) begin
      o_fault_count <= o_fault_count + 8'h01;
    end
  end
endmodule : pwm_bridge_model

/* verilog/enhanced_pwm_output_stage.sv */
`timescale 1ns/1ps
module enhanced_pwm_output_stage #(
  parameter bit ENHANCED = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_channel_control,
  input wire logic [7:0] i_duty_high_bits,
  input wire logic [7:0] i_period_limit,
  input wire logic [3:0] i_steer_enable,
  input wire logic [1:0] i_timer_prescale_select,
  input wire logic i_timer_run,
  input wire logic i_sleep,
  input wire logic i_match_flag_clear,
  input wire logic i_pin_direction_we,
  input wire logic [3:0] i_pin_direction,
  input wire logic [3:0] i_port_data,
  output logic [3:0] o_pin_out,
  output logic [3:0] o_pin_oe,
  output logic [3:0] o_pwm_owned,
  output logic o_timer_match_flag,
  output logic [7:0] o_base_timer_count,
  output logic [9:0] o_duty_active_shadow,
  output logic [3:0] o_resolution_bits
);
  pwm_timer_if tb ();

  pwm_time_base u_time_base (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .tb(tb)
  );

  logic [7:0] channel_control;
  logic [7:0] duty_high_bits;
  logic [7:0] period_limit;
  logic [3:0] steer;
  logic [1:0] prescale_sel;
  logic timer_run;
  logic [3:0] pin_direction;
  logic [1:0] output_mode_select;
  logic [1:0] polarity_select;
  logic [1:0] mode_act;
  logic [1:0] pol_act;
  logic [3:0] steer_act;
  logic [9:0] next_duty;
  logic [9:0] duty_active;
  logic pwm_en;
  logic modulated;
  logic pulse;
  logic oversize;
  logic [3:0] used;
  logic [3:0] level;
  logic [3:0] next_pin_out;
  logic [3:0] res_bits;
  pwm_pkg::run_state_t state;

  assign pwm_en = channel_control[pwm_pkg::SELECT_POS +: 2] == pwm_pkg::PWM_SELECT;
  // Second channel flavour ignores the mode field and steering
  assign output_mode_select = ENHANCED ? channel_control[pwm_pkg::MODE_POS +: 2] : pwm_pkg::MODE_SINGLE;
  assign polarity_select = channel_control[1:0];
  assign next_duty = {duty_high_bits, channel_control[pwm_pkg::DUTY_LOW_POS +: 2]};
  assign oversize = next_duty > {period_limit, pwm_pkg::FINE_LAST};
  assign tb.run_en = timer_run && !i_sleep;
  assign tb.prescale_select = prescale_sel;
  assign tb.period_limit = period_limit;
  assign tb.match_clear = i_match_flag_clear;
  assign o_timer_match_flag = tb.match_flag;
  assign o_base_timer_count = tb.count[9:2];
  assign o_duty_active_shadow = duty_active;
  assign o_resolution_bits = res_bits;
  assign o_pin_oe = ~pin_direction;
  // Match ends the pulse at once, so width is duty counts, not one more
  assign pulse = modulated && tb.count != duty_active;

  // Channel registers captured from software each cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      channel_control <= pwm_pkg::CONTROL_RESET;
      duty_high_bits <= 8'h00;
      period_limit <= 8'h00;
      steer <= 4'h0;
      prescale_sel <= 2'h0;
      timer_run <= 1'b0;
    end else begin
      channel_control <= i_channel_control;
      duty_high_bits <= i_duty_high_bits;
      period_limit <= i_period_limit;
      steer <= ENHANCED ? i_steer_enable : pwm_pkg::STEER_FIRST_ONLY;
      prescale_sel <= i_timer_prescale_select;
      timer_run <= i_timer_run;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pin_direction <= pwm_pkg::DIRECTION_RESET;
    end else if (i_pin_direction_we) begin
      pin_direction <= i_pin_direction;
    end
  end

  // Resolution is the top set bit of period+1, plus two
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      res_bits <= 4'h2;
    end else begin
      res_bits <= 4'h2;
      for (int b = 0; b < 9; b++) begin
        if ((({1'b0, period_limit} + 9'h001) >> b) != 9'h000) begin
          res_bits <= 4'(b + 2);
        end
      end
    end
  end

  // Armed until the first wrap so no partial waveform appears
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= pwm_pkg::ST_OFF;
    end else if (!pwm_en) begin
      state <= pwm_pkg::ST_OFF;
    end else if (!i_sleep) begin
      case (state)
        pwm_pkg::ST_OFF: begin
          state <= pwm_pkg::ST_ARMED;
        end
        pwm_pkg::ST_ARMED: begin
          if (tb.period_start) begin
            state <= pwm_pkg::ST_RUN;
          end
        end
        default: begin
          state <= pwm_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Shadows only move at a wrap, which keeps switching glitch free
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      duty_active <= 10'h000;
      mode_act <= pwm_pkg::MODE_SINGLE;
      pol_act <= 2'h0;
      steer_act <= 4'h0;
    end else if (tb.period_start && pwm_en) begin
      duty_active <= next_duty;
      mode_act <= output_mode_select;
      pol_act <= polarity_select;
      steer_act <= steer;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      modulated <= 1'b0;
    end else if (!pwm_en) begin
      modulated <= 1'b0;
    end else if (tb.period_start) begin
      if (!oversize) begin
        modulated <= next_duty != 10'h000;
      end
    end else if (tb.run_en && tb.count == duty_active) begin
      modulated <= 1'b0;
    end
  end

  always_comb begin
    used = 4'h0;
    level = 4'h0;
    case (mode_act)
      pwm_pkg::MODE_HALF: begin
        used = pwm_pkg::HALF_PINS;
        level = {2'b00, ~pulse, pulse};
      end
      pwm_pkg::MODE_FORWARD: begin
        used = pwm_pkg::ALL_PINS;
        level = {pulse, 2'b00, 1'b1};
      end
      pwm_pkg::MODE_REVERSE: begin
        used = pwm_pkg::ALL_PINS;
        level = {1'b0, 1'b1, pulse, 1'b0};
      end
      default: begin
        used = (steer_act[3:1] == 3'h0) ? pwm_pkg::STEER_FIRST_ONLY : steer_act;
        level = {4{pulse}};
      end
    endcase
  end

  // Pins A and C share one polarity bit, B and D the other
  for (genvar p = 0; p < 4; p++) begin : g_pin
    logic own;
    assign own = pwm_en && used[p];
    assign o_pwm_owned[p] = own;
    always_comb begin
      if (!own) begin
        next_pin_out[p] = i_port_data[p];
      end else if (state != pwm_pkg::ST_RUN) begin
        next_pin_out[p] = pol_act[p % 2];
      end else begin
        next_pin_out[p] = level[p] ^ pol_act[p % 2];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_pin_out <= 4'h0;
    end else if (!i_sleep || o_pwm_owned != 4'hf) begin
      o_pin_out <= next_pin_out;
    end
  end

  reset_dir_a: assert property (@(posedge i_clk)
    !i_resetn |=> o_pin_oe == 4'h0 && o_pwm_owned == 4'h0) else $error("Pins not inputs after reset");
  duty_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tb.period_start && pwm_en |=> duty_active == $past(next_duty)) else $error("Duty not loaded at wrap");
  wrap_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tb.period_start && pwm_en && !oversize && next_duty != 10'h000 |=> modulated) else $error("Output not set");
  oversize_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tb.period_start && pwm_en && oversize |=> modulated == $past(modulated)) else $error("Oversize changed");
  release_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    channel_control == 8'h00 |-> o_pwm_owned == 4'h0) else $error("Pins kept after release");
  half_pins_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    pwm_en && mode_act == pwm_pkg::MODE_HALF |-> o_pwm_owned == 4'h3) else $error("Half bridge pins wrong");
  first_period_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(pwm_en) |=> state != pwm_pkg::ST_RUN) else $error("Output before full period");
  resolution_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    period_limit == 8'hff [*2] |=> res_bits == 4'ha) else $error("Resolution not ten bits");
  forward_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    pwm_en && state == pwm_pkg::ST_RUN && mode_act == pwm_pkg::MODE_FORWARD && !i_sleep
    |=> o_pin_out[0] == !$past(pol_act[0]) && o_pin_out[1] == $past(pol_act[1])) else $error("Forward levels wrong");
endmodule : enhanced_pwm_output_stage

/* verilog/pwm_time_base.sv */
`timescale 1ns/1ps
module pwm_time_base (
  input wire logic i_clk,
  input wire logic i_resetn,
  pwm_timer_if.timer tb
);
  logic [3:0] presc;
  logic [3:0] presc_limit;
  logic [1:0] fine;
  logic [7:0] base_timer_count;
  logic tick;
  logic wrap;
  logic [4:0] gap;
  logic gap_ok;

  always_comb begin
    if (tb.prescale_select == pwm_pkg::PRESCALE_DIV1) begin
      presc_limit = pwm_pkg::PRESC_LIMIT_1;
    end else if (tb.prescale_select == pwm_pkg::PRESCALE_DIV4) begin
      presc_limit = pwm_pkg::PRESC_LIMIT_4;
    end else begin
      presc_limit = pwm_pkg::PRESC_LIMIT_16;
    end
  end

  // All timing counts system clocks, so frequency follows the clock
  assign tick = tb.run_en && (presc >= presc_limit);
  assign wrap = tick && fine == pwm_pkg::FINE_LAST && base_timer_count == tb.period_limit;
  assign tb.count = {base_timer_count, fine};
  assign tb.period_start = wrap;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      presc <= 4'h0;
    end else if (tb.run_en) begin
      presc <= tick ? 4'h0 : presc + 4'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      fine <= 2'h0;
      base_timer_count <= 8'h00;
    end else if (wrap) begin
      fine <= 2'h0;
      base_timer_count <= 8'h00;
    end else if (tick) begin
      fine <= fine + 2'h1;
      if (fine == pwm_pkg::FINE_LAST) begin
        base_timer_count <= base_timer_count + 8'h01;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tb.match_flag <= 1'b0;
    end else if (wrap) begin
      tb.match_flag <= 1'b1;
    end else if (tb.match_clear) begin
      tb.match_flag <= 1'b0;
    end
  end

  // Own count of running cycles between ticks, independent of the prescaler
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      gap <= 5'h00;
      gap_ok <= 1'b0;
    end else if (tick) begin
      gap <= 5'h00;
      gap_ok <= tb.prescale_select[1];
    end else begin
      if (tb.run_en && gap != 5'h1f) begin
        gap <= gap + 5'h01;
      end
      if (!tb.prescale_select[1]) begin
        gap_ok <= 1'b0;
      end
    end
  end

  timer_wrap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wrap |=> tb.count == 10'h000 && tb.match_flag) else $error("Timer not cleared at wrap");
  sleep_freeze_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !tb.run_en |=> $stable(tb.count)) else $error("Timer moved while stopped");
  div16_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    tick && gap_ok && tb.prescale_select[1] |-> gap == 5'h0f) else $error("Divide by 16 broken");
endmodule : pwm_time_base
